// file: ddrmb_pkg.sv
// constants, states and carriers for the ddr memory bus transaction block
package ddrmb_pkg;

  // word address width of the array
  localparam int DDRMB_ADDR_W = 24;
  // configured latency field width
  localparam int LAT_W = 4;
  // command/address phase: three clocks, two bytes each
  localparam int CMD_BYTES = 6;
  // bytes captured once row and upper column are known
  localparam int ROW_START_BYTE = 4;
  // command word field positions
  localparam int RW_BIT = 47;
  localparam int SPACE_BIT = 46;
  localparam int BURST_BIT = 45;
  localparam int ROW_HI = 44;
  localparam int ROW_LO = 16;
  localparam int COL_HI = 2;
  // smallest wrap length, log2 of words
  localparam int WRAP_BASE_LOG2 = 3;
  // reset values of driven pins
  localparam logic [7:0] DQ_RESET = 8'h00;
  localparam logic STROBE_RESET = 1'b0;
  // fifo depth in front of the array
  localparam int WR_FIFO_DEPTH = 4;

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_CMD  = 6'b000010,
    S_LAT  = 6'b000100,
    S_RD   = 6'b001000,
    S_WR   = 6'b010000,
    S_END  = 6'b100000
  } ddrmb_state_t;

  // one array write: word address, data, per-byte keep (1 = store)
  typedef struct packed {
    logic [DDRMB_ADDR_W-1:0] addr;
    logic [15:0] data;
    logic [1:0] keep;
  } ddrmb_wr_t;

  // one register-space write
  typedef struct packed {
    logic [DDRMB_ADDR_W-1:0] addr;
    logic [15:0] data;
  } ddrmb_reg_wr_t;

endpackage

// file: ddrmb_top.sv
// write fifo and device-side transaction logic of the ddr memory bus
//
// Function
// R01 - host starts a transaction by lowering chip select with clock low
// R02 - host raises chip select before starting any new transaction
// R03 - read array access starts once command bits 23:16 are captured
// R04 - read latency from config; strobe high in command doubles it
// R05 - memory drives the strobe line through read transactions
// R06 - register read sends bits 15:8 then 7:0, repeated every word
// R07 - command bit 47 low means write, bit 46 low means memory space
// R08 - write access may start after first two words; third picks word
// R09 - host clocks one latency count, or two if strobe was high
// R10 - write byte A captured on rising edge, byte B on falling edge
// R11 - memory drives strobe in command phase to flag extra latency
// R12 - during write data, mask high skips a byte, mask low stores it
// R13 - no latency inserted once write data has begun
// R14 - wrapped bursts wrap, hybrid wraps once, linear runs sequentially
// R15 - linear write past last address rolls over to address zero
// R16 - host may end a write anytime with clock idle; clock may stop
// R17 - memory releases strobe after command; host drives low preamble
// R18 - every transaction opens with three command/address clocks
// R19 - register writes have zero latency, data right after command
// R20 - zero-latency writes are unmasked; memory holds strobe low
// R21 - latency flag ignored for zero-latency register writes
// R22 - command bit 45 low means wrapped, high means linear
// R23 - command bit 46 high selects register space
// R24 - read bytes are edge-aligned with each strobe transition
// R25 - latency counted in whole clocks after the third command clock

////////////////////////////////////////////////////////////////////////
module ddrmb_fifo
  import ddrmb_pkg::*;
#(
  parameter int W = 8,
  parameter int DEPTH = 4
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic [PW:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_comb
  begin
    next_count = count;
    if (push && !pop)
      next_count = count + (PW+1)'(1);
    else if (pop && !push)
      next_count = count - (PW+1)'(1);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + PW'(1);
      if (pop)
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + PW'(1);
      count <= next_count;
      in_ready <= next_count < (PW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end
endmodule

////////////////////////////////////////////////////////////////////////
module ddrmb_top
  import ddrmb_pkg::*;
#(
  parameter int AW = DDRMB_ADDR_W
)
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // link pins
  input wire logic CS_N,
  input wire logic CK,
  input wire logic CLOCK_COMPLEMENT,
  input wire logic [7:0] DQ_IN,
  output logic [7:0] DQ_OUT,
  output logic DQ_OE_N,
  input wire logic STROBE_MASK_LINE_IN,
  output logic STROBE_MASK_LINE_OUT,
  output logic STROBE_MASK_LINE_OE_N,
  // configuration
  input wire logic [LAT_W-1:0] LATENCY,
  input wire logic ADD_LAT_REQ,
  input wire logic [1:0] BURST_SEL,
  input wire logic HYBRID_WRAP,
  input wire logic [15:0] REGISTER_VALUE,
  // array access
  output logic ACC_START,
  output logic ACC_READ,
  output logic [AW-1:0] ACC_ADDR,
  output logic [AW-1:0] ARR_RD_ADDR,
  input wire logic [15:0] ARR_RD_DATA,
  output logic ARR_WR_VALID,
  output ddrmb_wr_t ARR_WR,
  input wire logic ARR_WR_READY,
  // register writes and status
  output logic REG_WR_VALID,
  output ddrmb_reg_wr_t REG_WR,
  output logic BUSY,
  output logic WR_OVERRUN
);
  ddrmb_state_t state;
  logic cs_s1, cs_s2, ck_s1, ck_s2, ck_q, ckc_s1, ckc_s2;
  logic str_s1, str_s2;
  logic [7:0] dq_s1, dq_s2;
  logic rise, fall, edge_any, cs_high, start;
  logic [2:0] byte_cnt;
  logic [47:0] ca, ca_next;
  logic [31:0] ca_addr;
  logic lat_extra, is_read, is_reg, zero_lat, cmd_end, lat_done;
  logic [LAT_W:0] lat_cnt, lat_target;
  logic data_rise, data_a, adv;
  logic [AW-1:0] addr, start_addr, wrap_mask, next_addr, wcnt;
  logic lin_mode;
  logic [7:0] rd_low, wbyte_a;
  logic [15:0] rd_word;
  logic wmask_a;
  logic fifo_push, fifo_in_ready;
  ddrmb_wr_t fifo_in;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers and clock edge detection
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      {cs_s1, cs_s2} <= 2'h3;
      {ck_s1, ck_s2, ck_q} <= 3'h0;
      {ckc_s1, ckc_s2} <= 2'h3;
      {str_s1, str_s2} <= 2'h0;
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
    end
    else
    begin
      cs_s1 <= CS_N;
      cs_s2 <= cs_s1;
      ck_s1 <= CK;
      ck_s2 <= ck_s1;
      ck_q <= ck_s2;
      ckc_s1 <= CLOCK_COMPLEMENT;
      ckc_s2 <= ckc_s1;
      str_s1 <= STROBE_MASK_LINE_IN;
      str_s2 <= str_s1;
      dq_s1 <= DQ_IN;
      dq_s2 <= dq_s1;
    end
  end

  assign rise = ck_s2 && !ck_q;
  assign fall = !ck_s2 && ck_q;
  assign edge_any = rise || fall;
  // R16 deselect ends any phase
  assign cs_high = cs_s2;
  // R01 start only with clock idle low
  assign start = !cs_s2 && !ck_s2 && ckc_s2;
  assign ca_next = {ca[39:0], dq_s2};
  assign ca_addr = {ca_next[ROW_HI:ROW_LO], ca_next[COL_HI:0]};
  assign cmd_end = state == S_CMD && edge_any && !cs_high
                   && byte_cnt == 3'(CMD_BYTES-1);
  // R25 latency counted on rising edges
  assign lat_done = state == S_LAT && rise && !cs_high
                    && lat_cnt == lat_target;
  assign data_rise = !cs_high && rise
                     && (state == S_RD || state == S_WR || lat_done);
  assign adv = !cs_high && fall && data_a
               && (state == S_RD || state == S_WR);

  ////////////////////////////////////////////////////////////////////
  // transaction sequencing
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      state <= S_IDLE;
      byte_cnt <= 3'h0;
      ca <= 48'h0;
      lat_extra <= 1'b0;
      lat_cnt <= '0;
      lat_target <= '0;
      is_read <= 1'b0;
      is_reg <= 1'b0;
      zero_lat <= 1'b0;
    end
    else if (cs_high && state != S_IDLE)
      state <= S_IDLE;
    else
    begin
      case (state)
        S_IDLE:
          if (start)
          begin
            state <= S_CMD;
            byte_cnt <= 3'h0;
            lat_extra <= ADD_LAT_REQ;
          end
        S_CMD:
          if (edge_any)
          begin
            // R18 six command bytes over three clocks
            ca <= ca_next;
            byte_cnt <= byte_cnt + 3'h1;
            if (cmd_end)
            begin
              // R07 R23 direction and space decode
              is_read <= ca_next[RW_BIT];
              is_reg <= ca_next[SPACE_BIT];
              zero_lat <= !ca_next[RW_BIT] && ca_next[SPACE_BIT];
              lat_cnt <= '0;
              // R04 doubled latency on flag
              lat_target <= lat_extra ? {LATENCY, 1'b0}
                                      : {1'b0, LATENCY};
              // R19 R21 register write skips latency
              if (!ca_next[RW_BIT] && ca_next[SPACE_BIT])
                state <= S_WR;
              else
                state <= S_LAT;
            end
          end
        S_LAT:
          if (lat_done)
            state <= is_read ? S_RD : S_WR;
          else if (rise)
            lat_cnt <= lat_cnt + (LAT_W+1)'(1);
        S_RD, S_WR, S_END:
          state <= state;
        default:
          state <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // burst address generation
  assign wrap_mask = (AW'(1) << (WRAP_BASE_LOG2 + int'(BURST_SEL)))
                     - AW'(1);

  always_comb
  begin
    next_addr = addr + AW'(1);
    if (!lin_mode)
    begin
      if (HYBRID_WRAP && wcnt == wrap_mask)
        next_addr = (start_addr & ~wrap_mask) + wrap_mask + AW'(1);
      else
        next_addr = (addr & ~wrap_mask) | ((addr + AW'(1)) & wrap_mask);
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      addr <= '0;
      start_addr <= '0;
      lin_mode <= 1'b0;
      wcnt <= '0;
      data_a <= 1'b0;
    end
    else if (cmd_end)
    begin
      // R08 third word selects start word
      addr <= ca_addr[AW-1:0];
      start_addr <= ca_addr[AW-1:0];
      // R22 burst type bit
      lin_mode <= ca_next[BURST_BIT];
      wcnt <= '0;
      data_a <= 1'b0;
    end
    else if (data_rise)
      data_a <= 1'b1;
    else if (adv)
    begin
      // R14 R15 wrap, hybrid or linear rollover
      addr <= next_addr;
      wcnt <= wcnt + AW'(1);
      data_a <= 1'b0;
      if (HYBRID_WRAP && wcnt == wrap_mask)
        lin_mode <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // early array access and read address
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      ACC_START <= 1'b0;
      ACC_READ <= 1'b0;
      ACC_ADDR <= '0;
      ARR_RD_ADDR <= '0;
      BUSY <= 1'b0;
    end
    else
    begin
      // R03 R08 access begins at byte four
      ACC_START <= state == S_CMD && edge_any && !cs_high
                   && byte_cnt == 3'(ROW_START_BYTE-1);
      if (state == S_CMD && byte_cnt == 3'(ROW_START_BYTE-1))
      begin
        ACC_READ <= ca_next[31];
        ACC_ADDR <= {ca_next[AW-4:0], 3'h0};
      end
      ARR_RD_ADDR <= addr;
      BUSY <= state != S_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // strobe and data pin drive
  // R06 register read repeats value
  assign rd_word = is_reg ? REGISTER_VALUE : ARR_RD_DATA;

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      DQ_OUT <= DQ_RESET;
      DQ_OE_N <= 1'b1;
      STROBE_MASK_LINE_OUT <= STROBE_RESET;
      STROBE_MASK_LINE_OE_N <= 1'b1;
      rd_low <= 8'h00;
    end
    else if (cs_high || state == S_IDLE)
    begin
      DQ_OUT <= DQ_RESET;
      DQ_OE_N <= 1'b1;
      STROBE_MASK_LINE_OE_N <= !(state == S_IDLE && start && !cs_high);
      // R11 latency flag during command
      STROBE_MASK_LINE_OUT <= ADD_LAT_REQ;
    end
    else if (cmd_end)
    begin
      STROBE_MASK_LINE_OUT <= STROBE_RESET;
      // R05 R17 R20 keep for reads and register writes
      STROBE_MASK_LINE_OE_N <= !(ca_next[RW_BIT] || ca_next[SPACE_BIT]);
    end
    else if (is_read && data_rise)
    begin
      // R24 byte A with strobe rising
      DQ_OUT <= rd_word[15:8];
      DQ_OE_N <= 1'b0;
      STROBE_MASK_LINE_OUT <= 1'b1;
      rd_low <= rd_word[7:0];
    end
    else if (state == S_RD && adv)
    begin
      // R24 byte B with strobe falling
      DQ_OUT <= rd_low;
      STROBE_MASK_LINE_OUT <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // write data capture
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      wbyte_a <= 8'h00;
      wmask_a <= 1'b0;
      fifo_push <= 1'b0;
      fifo_in <= '0;
      REG_WR_VALID <= 1'b0;
      REG_WR <= '0;
      WR_OVERRUN <= 1'b0;
    end
    else
    begin
      fifo_push <= 1'b0;
      REG_WR_VALID <= 1'b0;
      // R10 byte A on rising edge
      if (data_rise && (state == S_WR || (state == S_LAT && !is_read)))
      begin
        wbyte_a <= dq_s2;
        wmask_a <= str_s2;
      end
      // R10 byte B on falling edge
      if (adv && state == S_WR)
      begin
        if (is_reg)
        begin
          REG_WR_VALID <= 1'b1;
          REG_WR <= '{addr: addr, data: {wbyte_a, dq_s2}};
        end
        else
        begin
          fifo_push <= 1'b1;
          fifo_in.addr <= addr;
          fifo_in.data <= {wbyte_a, dq_s2};
          // R12 mask high skips byte
          fifo_in.keep <= zero_lat ? 2'h3 : ~{wmask_a, str_s2};
        end
      end
      if (state == S_IDLE && start)
        WR_OVERRUN <= 1'b0;
      if (fifo_push && !fifo_in_ready)
        WR_OVERRUN <= 1'b1;
    end
  end

  ddrmb_fifo #(
    .W($bits(ddrmb_wr_t)),
    .DEPTH(WR_FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(REF_CLK),
    .rst(RST),
    .in_valid(fifo_push),
    .in_data(fifo_in),
    .in_ready(fifo_in_ready),
    .out_valid(ARR_WR_VALID),
    .out_data(ARR_WR),
    .out_ready(ARR_WR_READY)
  );

  ////////////////////////////////////////////////////////////////////
  // assertions and covers
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  property p_r03;
    (state == S_CMD && edge_any && !cs_high
     && byte_cnt == 3'(ROW_START_BYTE-1)) |=> ACC_START;
  endproperty
  a_r03: assert property (p_r03) else $error("access not started"); // R03

  property p_r04;
    cmd_end && ca_next[RW_BIT] |=> lat_target ==
      (lat_extra ? {$past(LATENCY), 1'b0} : {1'b0, $past(LATENCY)});
  endproperty
  a_r04: assert property (p_r04) else $error("bad read latency"); // R04

  property p_r05;
    state == S_RD |-> !STROBE_MASK_LINE_OE_N;
  endproperty
  a_r05: assert property (p_r05) else $error("strobe not driven"); // R05

  property p_r06;
    (state == S_RD && rise && is_reg && !cs_high)
      |=> DQ_OUT == $past(REGISTER_VALUE[15:8]);
  endproperty
  a_r06: assert property (p_r06) else $error("bad register byte"); // R06

  property p_r11;
    state == S_CMD |-> !STROBE_MASK_LINE_OE_N
                       && STROBE_MASK_LINE_OUT == lat_extra;
  endproperty
  a_r11: assert property (p_r11) else $error("no latency flag"); // R11

  property p_r12;
    (adv && state == S_WR && !is_reg)
      |=> fifo_push && fifo_in.keep == ~{$past(wmask_a), $past(str_s2)};
  endproperty
  a_r12: assert property (p_r12) else $error("bad byte mask"); // R12

  property p_r13;
    state == S_WR && !is_reg |-> STROBE_MASK_LINE_OE_N;
  endproperty
  a_r13: assert property (p_r13) else $error("strobe during data"); // R13

  property p_r17;
    cmd_end && !ca_next[RW_BIT] && !ca_next[SPACE_BIT]
      |=> STROBE_MASK_LINE_OE_N [*2];
  endproperty
  a_r17: assert property (p_r17) else $error("strobe not released"); // R17

  property p_r19;
    cmd_end && !ca_next[RW_BIT] && ca_next[SPACE_BIT] |=> state == S_WR;
  endproperty
  a_r19: assert property (p_r19) else $error("register latency"); // R19

  property p_r15;
    adv && lin_mode && addr == '1 |=> addr == '0;
  endproperty
  a_r15: assert property (p_r15) else $error("no rollover"); // R15

  c_read: cover property (state == S_RD ##1 state == S_IDLE);
  c_mem_write: cover property (fifo_push && !is_reg);
  c_reg_write: cover property (REG_WR_VALID);
  c_extra_lat: cover property (lat_done && lat_extra && is_read);
endmodule

// file: ddrmb_host.sv
// host bus master model driving chip select, link clock, data and mask
module ddrmb_host
(
  // clock
  input wire logic clk,
  // link outputs
  output logic cs_n,
  output logic ck,
  output logic [7:0] dq,
  output logic s_val,
  // link inputs
  input wire logic [7:0] dq_dev,
  input wire logic dq_oe_n,
  input wire logic s_dev
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rd_b [32];
  logic rd_m [32];
  logic cmd_s;
  logic lat_oe;

  initial
  begin
    cs_n = 1'b1;
    ck = 1'b0;
    dq = 8'h00;
    s_val = 1'b1;
  end

  task automatic hw(input int n);
    repeat (n) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic [47:0] ca, input int nl, input int nw,
    input logic [15:0] wd [16], input logic [1:0] mk [16]);
    int ne;
    int d;
    logic mw;
    ne = 6 + 2 * nl + 2 * nw;
    mw = !ca[47] && nl > 0;
    lat_oe = 1'b1;
    dq <= ca[47:40];
    cs_n <= 1'b0;
    hw(10);
    for (int e = 0; e < ne; e++)
    begin
      ck <= ~ck;
      hw(5);
      d = e + 1 - 6 - 2 * nl;
      if (e < 5)
        dq <= ca[39 - 8 * e -: 8];
      else if (d >= 0 && d < 2 * nw)
      begin
        dq <= d[0] ? wd[d / 2][7:0] : wd[d / 2][15:8];
        if (mw)
          s_val <= d[0] ? mk[d / 2][0] : mk[d / 2][1];
      end
      else if (mw)
        s_val <= 1'b0;
      else if (e == 5 && ca[47])
        dq <= ~dq;
      hw(3);
      if (e == 3)
        cmd_s = s_dev;
      if (e >= 6 && d <= 0)
        lat_oe &= dq_oe_n;
      else if (d > 0)
      begin
        rd_b[d - 1] = dq_dev;
        rd_m[d - 1] = s_dev;
      end
      hw(2);
    end
    hw(5);
    cs_n <= 1'b1;
    dq <= ~dq;
    s_val <= ~s_val;
    hw(20);
  endtask
endmodule

// file: ddrmb_top_bench.sv
// self-checking bench for the ddr memory bus transaction block
module ddrmb_top_bench
  import ddrmb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, cs_n, ck, s_val, dq_oe_n, sm_out, sm_oe_n, sm_w;
  logic add, hyb, wready, acc_start, acc_read, wvalid, rvalid, busy, ovr;
  logic [7:0] h_dq, dq_out, dq_w;
  logic [LAT_W-1:0] lat;
  logic [1:0] bsel;
  logic [15:0] regv, rdata;
  logic [23:0] acc_addr, rd_addr, acc_a;
  logic acc_seen, acc_rd, busy_seen;
  ddrmb_wr_t arr_wr;
  ddrmb_reg_wr_t reg_wr;
  ddrmb_wr_t wq [$];
  ddrmb_reg_wr_t rq [$];
  logic [15:0] wd [16];
  logic [1:0] mk [16];
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;

  assign dq_w = dq_oe_n ? h_dq : dq_out;
  assign sm_w = sm_oe_n ? s_val : sm_out;
  assign rdata = {rd_addr[7:0], ~rd_addr[7:0]};

  ddrmb_top DUT (.REF_CLK(ref_clk), .RST(rst), .CS_N(cs_n), .CK(ck),
    .CLOCK_COMPLEMENT(~ck), .DQ_IN(dq_w), .DQ_OUT(dq_out),
    .DQ_OE_N(dq_oe_n), .STROBE_MASK_LINE_IN(sm_w),
    .STROBE_MASK_LINE_OUT(sm_out), .STROBE_MASK_LINE_OE_N(sm_oe_n),
    .LATENCY(lat), .ADD_LAT_REQ(add), .BURST_SEL(bsel), .HYBRID_WRAP(hyb),
    .REGISTER_VALUE(regv), .ACC_START(acc_start), .ACC_READ(acc_read),
    .ACC_ADDR(acc_addr), .ARR_RD_ADDR(rd_addr), .ARR_RD_DATA(rdata),
    .ARR_WR_VALID(wvalid), .ARR_WR(arr_wr), .ARR_WR_READY(wready),
    .REG_WR_VALID(rvalid), .REG_WR(reg_wr), .BUSY(busy), .WR_OVERRUN(ovr));

  ddrmb_host u_host (.clk(ref_clk), .cs_n(cs_n), .ck(ck), .dq(h_dq),
    .s_val(s_val), .dq_dev(dq_w), .dq_oe_n(dq_oe_n), .s_dev(sm_w));

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (wvalid && wready)
      wq.push_back(arr_wr);
    if (rvalid)
      rq.push_back(reg_wr);
    if (busy)
      busy_seen = 1'b1;
    if (acc_start)
    begin
      acc_seen = 1'b1;
      acc_rd = acc_read;
      acc_a = acc_addr;
    end
    if (cyc > 20000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  function automatic logic [47:0] mkca(logic r, logic s, logic b,
    logic [23:0] a);
    return {r, s, b, 8'h00, a[23:3], 13'h0000, a[2:0]};
  endfunction

  task automatic cfg(input logic [3:0] l, input logic a, input logic [1:0] b,
    input logic h);
    @(posedge ref_clk);
    lat <= l;
    add <= a;
    bsel <= b;
    hyb <= h;
  endtask

  task automatic go(input logic [47:0] ca, input int nl, input int nw);
    wq.delete();
    rq.delete();
    acc_seen = 1'b0;
    busy_seen = 1'b0;
    u_host.xfer(ca, nl, nw, wd, mk);
    repeat (10) @(posedge ref_clk);
  endtask

  task automatic cw(input int i, input logic [23:0] a, input logic [1:0] k);
    chk(wq[i].addr, a);
    chk(wq[i].data, wd[i]);
    chk(wq[i].keep, k);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reg_rd();
    cfg(4'h1, 1'b0, 2'h0, 1'b0);
    go(mkca(1'b1, 1'b1, 1'b1, 24'h000001), 1, 2);
    chk(u_host.cmd_s, 1'b0);
    chk(u_host.lat_oe, 1'b1);
    chk({busy_seen, busy}, 2'b10);
    for (int i = 0; i < 4; i++)
    begin
      chk(u_host.rd_b[i], i[0] ? regv[7:0] : regv[15:8]);
      chk(u_host.rd_m[i], !i[0]);
    end
  endtask

  task automatic t_reg_rd_x();
    cfg(4'h2, 1'b1, 2'h0, 1'b0);
    go(mkca(1'b1, 1'b1, 1'b1, 24'h000000), 4, 1);
    chk(u_host.cmd_s, 1'b1);
    chk(u_host.lat_oe, 1'b1);
    chk(u_host.rd_b[0], regv[15:8]);
    chk(u_host.rd_b[1], regv[7:0]);
  endtask

  task automatic t_mem_rd();
    logic [23:0] a;
    cfg(4'h3, 1'b0, 2'h0, 1'b0);
    go(mkca(1'b1, 1'b0, 1'b1, 24'h000106), 3, 3);
    chk({acc_seen, acc_rd, acc_a}, {2'b11, 24'h000100});
    for (int i = 0; i < 3; i++)
    begin
      a = 24'h000106 + 24'(i);
      chk({u_host.rd_b[2 * i], u_host.rd_b[2 * i + 1]}, {a[7:0], ~a[7:0]});
    end
  endtask

  task automatic t_wr_roll();
    cfg(4'h2, 1'b1, 2'h0, 1'b0);
    mk[0] = 2'b10;
    mk[1] = 2'b01;
    go(mkca(1'b0, 1'b0, 1'b1, 24'hffffff), 4, 2);
    mk[0] = 2'b00;
    mk[1] = 2'b00;
    chk({acc_seen, acc_rd}, 2'b10);
    chk(wq.size(), 2);
    cw(0, 24'hffffff, 2'b01);
    cw(1, 24'h000000, 2'b10);
  endtask

  task automatic t_wr_wrap();
    cfg(4'h1, 1'b0, 2'h1, 1'b0);
    go(mkca(1'b0, 1'b0, 1'b0, 24'h00001e), 1, 4);
    chk(wq.size(), 4);
    for (int i = 0; i < 4; i++)
      cw(i, 24'h000010 | 24'((14 + i) % 16), 2'b11);
  endtask

  task automatic t_wr_hyb();
    cfg(4'h1, 1'b0, 2'h0, 1'b1);
    go(mkca(1'b0, 1'b0, 1'b0, 24'h000026), 1, 10);
    chk(wq.size(), 10);
    for (int i = 0; i < 10; i++)
      cw(i, i < 8 ? 24'h20 | 24'((6 + i) % 8) : 24'h20 + 24'(i), 2'b11);
  endtask

  task automatic t_reg_wr();
    cfg(4'h3, 1'b1, 2'h0, 1'b0);
    go(mkca(1'b0, 1'b1, 1'b1, 24'h000002), 0, 2);
    chk(wq.size(), 0);
    chk(rq.size(), 2);
    chk(rq[0].addr, 24'h000002);
    for (int i = 0; i < 2; i++)
      chk(rq[i].data, wd[i]);
    for (int i = 0; i < 4; i++)
      chk(u_host.rd_m[i], 1'b0);
  endtask

  task automatic t_ovr();
    cfg(4'h1, 1'b0, 2'h0, 1'b0);
    wready <= 1'b0;
    go(mkca(1'b0, 1'b0, 1'b1, 24'h000040), 1, 5);
    chk({ovr, wvalid, 8'(wq.size())}, {2'b11, 8'h00});
    wready <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk({wvalid, 8'(wq.size())}, {1'b0, 8'h04});
    for (int i = 0; i < 4; i++)
      cw(i, 24'h000040 + 24'(i), 2'b11);
  endtask

  initial
  begin
    rst = 1'b1;
    lat = 4'h1;
    add = 1'b0;
    bsel = 2'h0;
    hyb = 1'b0;
    regv = 16'hc35a;
    wready = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      wd[i] = {8'ha0 + 8'(i), 8'h50 + 8'(i)};
      mk[i] = 2'b00;
    end
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (5) @(posedge ref_clk);
    t_reg_rd();
    t_reg_rd_x();
    t_mem_rd();
    t_wr_roll();
    t_wr_wrap();
    t_wr_hyb();
    t_reg_wr();
    t_ovr();
    wrap_up();
  end
endmodule
